// ===== logic/ctf_pkg.sv
// package: register map, fields and carriers of the can transmit flag block
`default_nettype none
package ctf_pkg;
    localparam int NUM_TX = 3;
    localparam int NUM_DATA = 8;
    // word byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_TX_FLAGS  = 8'h08;
    localparam logic [7:0] ADDR_TX_IRQ_EN = 8'h0c;
    localparam logic [7:0] ADDR_RX_FLAGS  = 8'h10;
    localparam logic [7:0] ADDR_RX_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_ABORT_REQ = 8'h18;
    localparam logic [7:0] ADDR_ABORT_ACK = 8'h1c;
    localparam logic [7:0] ADDR_FILT_MODE = 8'h20;
    localparam logic [7:0] ADDR_ACC_CODE  = 8'h40;
    localparam logic [7:0] ADDR_ACC_MASK  = 8'h60;
    localparam logic [7:0] ADDR_TXBUF     = 8'h80;
    // ctrl fields
    localparam int CTRL_INIT_RQ = 0;
    localparam int CTRL_LISTEN  = 1;
    localparam int CTRL_WUP_EN  = 2;
    localparam int CTRL_SLEEP   = 3;
    // rx flag / enable fields
    localparam int RXF_WUP  = 7;
    localparam int RXF_CSC  = 6;
    localparam int RXF_OVR  = 1;
    localparam int RXF_FULL = 0;
    // identifier byte one fields
    localparam int ID1_RTR = 4;
    localparam int ID1_IDE = 3;
    localparam int STD_ID_W = 11;
    localparam logic [2:0] TX_FLAGS_RST = 3'h7;
    localparam logic [1:0] FILT_FOUR   = 2'h1;
    localparam logic [1:0] FILT_EIGHT  = 2'h2;
    localparam logic [1:0] FILT_CLOSED = 2'h3;

    typedef struct packed {
        logic        valid;
        logic [31:0] id_bytes;
        logic        overrun;
    } ctf_rx_evt_t;

    typedef struct packed {
        logic [1:0] tx_state;
        logic [1:0] rx_state;
    } ctf_bus_state_t;

    typedef struct packed {
        logic wakeup;
        logic error;
        logic receive;
        logic transmit;
    } ctf_irq_t;
endpackage
`default_nettype wire

// ===== logic/ctf_core.sv
// top: transmit empty flags, tx buffers, acceptance filters and interrupt requests
// Functional notes
// - flags held at reset during init mode
// - write one clears flag, zero ignored
// - three empty flags, bits 2 to 0
// - successful transmit sets empty flag
// - successful abort sets empty flag
// - clearing flag clears abort acknowledge
// - flag setting clears abort request
// - listen-only: no clear, no transmission
// - scheduled buffer blocks software access
// - tx irq pending while enabled flag set
// - eleven bit id, smallest wins
// - bit 4 of id byte one: rtr
// - bit 3 of id byte one: ide
// - eight data bytes, length code limits
// - four filters compare sixteen id bits
// - bank one filters 0-1, bank two 2-3
// - eight filters compare eight id bits
// - closed filter never sets receive full
// - four interrupts, each locally enabled
// - accepted frame sets receive full
// - bus activity in sleep raises wakeup
// - overrun or state change raises error
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`default_nettype none
module ctf_core #(
    parameter int NTX = 3
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic                    init_acknowledge,
    input  wire logic [2:0]              tx_done,
    input  wire logic [2:0]              abort_done,
    input  wire logic                    bus_activity,
    input  wire ctf_pkg::ctf_rx_evt_t    rx_evt,
    input  wire ctf_pkg::ctf_bus_state_t bus_state,
    input  wire logic                    global_irq_mask,
    output logic [2:0]                   tx_pending,
    output logic                         init_request,
    output logic                         rx_accept,
    output logic [7:0]                   filter_hit,
    output ctf_pkg::ctf_irq_t            irq
);
    import ctf_pkg::*;

    // the flag and buffer logic is laid out for exactly three buffers
    if (NTX != NUM_TX) begin : g_bad_ntx
        $error("ctf_core supports exactly three transmit buffers");
    end

    logic [3:0]       ctrl_r;
    logic [2:0]       tx_empty_r;
    logic [2:0]       tx_ie_r;
    logic [7:0]       rx_flags_r;
    logic [7:0]       rx_ie_r;
    logic [2:0]       abort_req_r;
    logic [2:0]       abort_ack_r;
    logic [1:0]       filt_mode_r;
    logic [7:0]       acc_code_r [8];
    logic [7:0]       acc_mask_r [8];
    logic [7:0]       txbuf_r [NUM_TX][16];
    ctf_bus_state_t   bus_state_r;
    logic [31:0]      rd_nxt;

    wire        req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wr        = req && wb_we_i && wb_sel_i[0];
    wire        in_init   = ctrl_r[CTRL_INIT_RQ] && init_acknowledge;
    wire        listen    = ctrl_r[CTRL_LISTEN];
    wire [1:0]  buf_sel   = wb_adr_i[7:6] - 2'h2;
    wire [3:0]  buf_byte  = wb_adr_i[5:2];
    wire        buf_hit   = wb_adr_i[7] && (buf_sel < 2'h3);
    wire        buf_open  = buf_hit && tx_empty_r[buf_sel];
    wire        flag_wr   = wr && (wb_adr_i == ADDR_TX_FLAGS) && !listen
                            && !ctrl_r[CTRL_INIT_RQ] && !init_acknowledge;
    wire [2:0]  clr_req   = flag_wr ? wb_dat_i[2:0] : 3'h0;
    wire [2:0]  set_ev    = tx_done | (abort_done & abort_req_r);
    wire [2:0]  flag_nxt  = (tx_empty_r & ~clr_req) | set_ev;  // set wins

    // bus slave, one wait state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_nxt : 32'h0;
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        unique case (1'b1)
            wb_adr_i == ADDR_CTRL:      rd_nxt = {28'h0, ctrl_r};
            wb_adr_i == ADDR_STATUS:    rd_nxt = {27'h0, bus_state_r, in_init};
            wb_adr_i == ADDR_TX_FLAGS:  rd_nxt = {29'h0, tx_empty_r};
            wb_adr_i == ADDR_TX_IRQ_EN: rd_nxt = {29'h0, tx_ie_r};
            wb_adr_i == ADDR_RX_FLAGS:  rd_nxt = {24'h0, rx_flags_r};
            wb_adr_i == ADDR_RX_IRQ_EN: rd_nxt = {24'h0, rx_ie_r};
            wb_adr_i == ADDR_ABORT_REQ: rd_nxt = {29'h0, abort_req_r};
            wb_adr_i == ADDR_ABORT_ACK: rd_nxt = {29'h0, abort_ack_r};
            wb_adr_i == ADDR_FILT_MODE: rd_nxt = {30'h0, filt_mode_r};
            wb_adr_i[7:5] == 3'h2:      rd_nxt = {24'h0, acc_code_r[wb_adr_i[4:2]]};
            wb_adr_i[7:5] == 3'h3:      rd_nxt = {24'h0, acc_mask_r[wb_adr_i[4:2]]};
            buf_open:                   rd_nxt = {24'h0, txbuf_r[buf_sel][buf_byte]};
            default:                    rd_nxt = 32'h0;
        endcase
    end

    // control and configuration
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r      <= 4'h1;
            tx_ie_r     <= 3'h0;
            rx_ie_r     <= 8'h0;
            filt_mode_r <= 2'h0;
        end else if (wr) begin
            if (wb_adr_i == ADDR_CTRL)      ctrl_r      <= wb_dat_i[3:0];
            if (wb_adr_i == ADDR_TX_IRQ_EN) tx_ie_r     <= wb_dat_i[2:0];
            if (wb_adr_i == ADDR_RX_IRQ_EN) rx_ie_r     <= wb_dat_i[7:0];
            if (wb_adr_i == ADDR_FILT_MODE) filt_mode_r <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!rst_n) begin
                acc_code_r[i] <= 8'h0;
                acc_mask_r[i] <= 8'h0;
            end else if (wr && wb_adr_i[7:5] == 3'h2 && wb_adr_i[4:2] == 3'(i)) begin
                acc_code_r[i] <= wb_dat_i[7:0];
            end else if (wr && wb_adr_i[7:5] == 3'h3 && wb_adr_i[4:2] == 3'(i)) begin
                acc_mask_r[i] <= wb_dat_i[7:0];
            end
        end
    end

    // transmit buffers: id bytes 0-3, data bytes 4-11, length 12, priority 13
    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < NUM_TX; b++) begin
            for (int k = 0; k < 16; k++) begin
                if (!rst_n) begin
                    txbuf_r[b][k] <= 8'h0;
                end else if (wr && buf_open && buf_sel == 2'(b) && buf_byte == 4'(k)) begin
                    txbuf_r[b][k] <= wb_dat_i[7:0];
                end
            end
        end
    end

    // transmit empty flags and abort handshake
    always_ff @(posedge ref_clk) begin
        if (!rst_n || in_init) begin
            tx_empty_r <= TX_FLAGS_RST;
        end else begin
            tx_empty_r <= flag_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || in_init) begin
            abort_req_r <= 3'h0;
            abort_ack_r <= 3'h0;
        end else begin
            for (int i = 0; i < NUM_TX; i++) begin
                if (set_ev[i]) begin
                    abort_req_r[i] <= 1'b0;
                end else if (wr && wb_adr_i == ADDR_ABORT_REQ && wb_dat_i[i] && !tx_empty_r[i]) begin
                    abort_req_r[i] <= 1'b1;
                end
                if (abort_done[i] && abort_req_r[i]) begin
                    abort_ack_r[i] <= 1'b1;
                end else if (clr_req[i] && tx_empty_r[i]) begin
                    abort_ack_r[i] <= 1'b0;
                end
            end
        end
    end

    // scheduled buffers go to the transmitter, none while listening
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_pending   <= 3'h0;
            init_request <= 1'b1;
        end else begin
            tx_pending   <= listen ? 3'h0 : ~flag_nxt;
            init_request <= ctrl_r[CTRL_INIT_RQ];
        end
    end

    // acceptance filters on the received identifier bytes
    logic [7:0] hit_w;
    logic [7:0] idb [4];
    always_comb begin
        idb[0] = rx_evt.id_bytes[31:24];
        idb[1] = rx_evt.id_bytes[23:16];
        idb[2] = rx_evt.id_bytes[15:8];
        idb[3] = rx_evt.id_bytes[7:0];
        hit_w  = 8'h0;
        for (int f = 0; f < 8; f++) begin
            if (filt_mode_r == FILT_EIGHT) begin
                hit_w[f] = ((idb[0] ^ acc_code_r[f]) & ~acc_mask_r[f]) == 8'h0;
            end else if (filt_mode_r == FILT_FOUR && f < 4) begin
                // filters 0-1 from bank one, 2-3 from bank two
                hit_w[f] = ((idb[0] ^ acc_code_r[2*f]) & ~acc_mask_r[2*f]) == 8'h0
                        && ((idb[1] ^ acc_code_r[2*f+1]) & ~acc_mask_r[2*f+1]) == 8'h0;
            end
        end
    end
    wire accept = rx_evt.valid && (filt_mode_r != FILT_CLOSED)
                  && (filt_mode_r == 2'h0 || hit_w != 8'h0);

    // receive, wakeup and error flags; write one clears, set wins
    logic [7:0] rx_set;
    always_comb begin
        rx_set           = 8'h0;
        rx_set[RXF_FULL] = accept;
        rx_set[RXF_OVR]  = rx_evt.overrun;
        rx_set[RXF_CSC]  = bus_state != bus_state_r;
        rx_set[RXF_WUP]  = bus_activity && ctrl_r[CTRL_SLEEP] && ctrl_r[CTRL_WUP_EN];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || in_init) begin
            rx_flags_r  <= 8'h0;
            bus_state_r <= '0;
            rx_accept   <= 1'b0;
            filter_hit  <= 8'h0;
        end else begin
            rx_flags_r  <= (rx_flags_r & ~((wr && wb_adr_i == ADDR_RX_FLAGS) ? wb_dat_i[7:0] : 8'h0)) | rx_set;
            bus_state_r <= bus_state;
            rx_accept   <= accept;
            // keep the hits of the last received frame
            if (rx_evt.valid) begin
                filter_hit <= hit_w;
            end
        end
    end

    // interrupt request outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= '0;
        end else begin
            irq.transmit <= !global_irq_mask && |(flag_nxt & tx_ie_r);
            irq.receive  <= !global_irq_mask && rx_flags_r[RXF_FULL] && rx_ie_r[RXF_FULL];
            irq.wakeup   <= !global_irq_mask && rx_flags_r[RXF_WUP] && rx_ie_r[RXF_WUP];
            irq.error    <= !global_irq_mask && ((rx_flags_r[RXF_CSC] && rx_ie_r[RXF_CSC])
                            || (rx_flags_r[RXF_OVR] && rx_ie_r[RXF_OVR]));
        end
    end
endmodule
`default_nettype wire

// ===== dv/ctf_core_sva.sv
// checker: bus handshake, flag and interrupt timing at the block's ports
`default_nettype none
module ctf_core_sva (
    input wire logic                 ref_clk,
    input wire logic                 rst_n,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire logic                 init_acknowledge,
    input wire logic [2:0]           tx_done,
    input wire logic                 global_irq_mask,
    input wire logic [2:0]           tx_pending,
    input wire logic                 init_request,
    input wire logic                 rx_accept,
    input wire ctf_pkg::ctf_rx_evt_t rx_evt,
    input wire ctf_pkg::ctf_irq_t    irq
);
    import ctf_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_init2;
        (init_request && init_acknowledge) [*2];
    endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_init_holds_empty: assert property (s_init2 |-> tx_pending == 3'h0)
        else $error("buffer scheduled during init");
    a_done_sets_empty: assert property (tx_done != 3'h0 |-> ##2 (tx_pending & $past(tx_done, 2)) == 3'h0)
        else $error("sent buffer still scheduled");
    a_irq_mask_gates: assert property (global_irq_mask [*2] |-> irq == 4'h0)
        else $error("request while globally masked");
    a_tx_irq_cause: assert property (irq.transmit |-> tx_pending != 3'h7)
        else $error("transmit request with no empty buffer");
    a_accept_cause: assert property (rx_accept |-> $past(rx_evt.valid) || $past(rx_evt.valid, 2))
        else $error("accept without received frame");
endmodule
bind ctf_core ctf_core_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .init_acknowledge(init_acknowledge), .tx_done(tx_done),
    .global_irq_mask(global_irq_mask), .tx_pending(tx_pending), .init_request(init_request),
    .rx_accept(rx_accept), .rx_evt(rx_evt), .irq(irq));
`default_nettype wire

// ===== dv/ctf_node_mdl.sv
// far-side model: controller core that acknowledges init and sends scheduled buffers
`default_nettype none
module ctf_node_mdl #(
    parameter int FAST = 3,
    parameter int SLOW = 60
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       slow,
    input  wire logic       init_request,
    input  wire logic [2:0] tx_pending,
    output logic            init_acknowledge,
    output logic [2:0]      tx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always @(posedge ref_clk) begin
        tx_done <= 3'h0;
        init_acknowledge <= rst_n & init_request;
        if (!rst_n || tx_pending == 3'h0) begin
            cnt <= 0;
        end else if (cnt >= (slow ? SLOW : FAST)) begin
            cnt <= 0;
            tx_done <= tx_pending & (~tx_pending + 3'h1);
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench: register-level tests of the transmit flag block
`default_nettype none
module tb;
    import ctf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ia, rq, rx_accept;
    logic act = 1'b0, gmask = 1'b0, slow = 1'b0;
    logic [7:0]     adr = 8'h0, filter_hit;
    logic [31:0]    wdat = 32'h0, rdat;
    logic [2:0]     abort = 3'h0, txd, tx_pending;
    ctf_rx_evt_t    rxe = '0;
    ctf_bus_state_t bst = '0;
    ctf_irq_t       irq;
    int n_fail = 0, num_checks = 0, n_acc = 0, cycles = 0;
    always #2 ref_clk = ~ref_clk;
    ctf_core #(.NTX(3)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .init_acknowledge(ia), .tx_done(txd), .abort_done(abort), .bus_activity(act), .rx_evt(rxe),
        .bus_state(bst), .global_irq_mask(gmask), .tx_pending(tx_pending), .init_request(rq),
        .rx_accept(rx_accept), .filter_hit(filter_hit), .irq(irq));
    ctf_node_mdl node (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .init_request(rq),
        .tx_pending(tx_pending), .init_acknowledge(ia), .tx_done(txd));
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (rx_accept === 1'b1) n_acc++;
        if (cycles == 4000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // look at ack where it is settled, release on the edge that sees it
        do @(negedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        @(posedge ref_clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h0, q);
        chk(q, {24'h0, e});
    endtask
    task automatic evt(input logic [31:0] id, input logic o);
        @(posedge ref_clk) rxe <= '{1'b1, id, o};
        @(posedge ref_clk) rxe <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rc(ADDR_CTRL, 8'h01);
        rc(ADDR_TX_FLAGS, 8'h07);
        wr(ADDR_TX_FLAGS, 8'h07);
        rc(ADDR_TX_FLAGS, 8'h07);
        wr(ADDR_CTRL, 8'h00);
        rc(8'h30, 8'h00);
        wr(ADDR_TX_IRQ_EN, 8'h07);
        wr(8'h90, 8'ha5);
        rc(8'h90, 8'ha5);
        wr(8'h84, 8'h18);
        rc(8'h84, 8'h18);
        chk({28'h0, irq}, 32'h1);
        $display("test init_and_buffers done");
        slow <= 1'b1;
        wr(ADDR_TX_FLAGS, 8'h01);
        wr(ADDR_TX_FLAGS, 8'h00);
        rc(ADDR_TX_FLAGS, 8'h06);
        chk({29'h0, tx_pending}, 32'h1);
        rc(8'h90, 8'h00);
        wr(ADDR_ABORT_REQ, 8'h01);
        rc(ADDR_ABORT_REQ, 8'h01);
        @(posedge ref_clk) abort <= 3'h1;
        @(posedge ref_clk) abort <= 3'h0;
        rc(ADDR_TX_FLAGS, 8'h07);
        rc(ADDR_ABORT_REQ, 8'h00);
        rc(ADDR_ABORT_ACK, 8'h01);
        wr(ADDR_TX_FLAGS, 8'h01);
        rc(ADDR_ABORT_ACK, 8'h00);
        slow <= 1'b0;
        wr(ADDR_TX_FLAGS, 8'h06);
        for (int i = 0; i < 300 && tx_pending !== 3'h0; i++) @(posedge ref_clk);
        rc(ADDR_TX_FLAGS, 8'h07);
        $display("test schedule_abort_send done");
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_TX_FLAGS, 8'h07);
        rc(ADDR_TX_FLAGS, 8'h07);
        chk({29'h0, tx_pending}, 32'h0);
        wr(ADDR_CTRL, 8'h00);
        gmask <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({28'h0, irq}, 32'h0);
        gmask <= 1'b0;
        wr(ADDR_TX_IRQ_EN, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk({28'h0, irq}, 32'h0);
        $display("test listen_and_mask done");
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_ACC_CODE + 8'(4 * i), 8'h10 + 8'(i));
            wr(ADDR_ACC_MASK + 8'(4 * i), 8'h00);
        end
        wr(ADDR_FILT_MODE, {6'h0, FILT_EIGHT});
        evt(32'h1300_0000, 1'b0);
        chk({24'h0, filter_hit}, 32'h08);
        wr(ADDR_FILT_MODE, {6'h0, FILT_FOUR});
        evt(32'h1213_0000, 1'b0);
        chk({24'h0, filter_hit}, 32'h02);
        wr(ADDR_RX_FLAGS, 8'hc3);
        wr(ADDR_FILT_MODE, {6'h0, FILT_CLOSED});
        evt(32'h1300_0000, 1'b0);
        rc(ADDR_RX_FLAGS, 8'h00);
        chk(32'(n_acc), 32'h2);
        $display("test filters done");
        wr(ADDR_FILT_MODE, 8'h00);
        wr(ADDR_RX_IRQ_EN, 8'hc3);
        evt(32'h0, 1'b1);
        bst <= 4'h5;
        wr(ADDR_CTRL, 8'h0c);
        @(posedge ref_clk) act <= 1'b1;
        @(posedge ref_clk) act <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rc(ADDR_RX_FLAGS, 8'hc3);
        rc(ADDR_STATUS, 8'h0a);
        chk({28'h0, irq}, 32'he);
        wr(ADDR_RX_FLAGS, 8'hc3);
        repeat (3) @(posedge ref_clk);
        chk({28'h0, irq}, 32'h0);
        $display("test receive_irqs done");
        final_report();
    end
endmodule
`default_nettype wire
